// [rtl/fss_regs.svh]
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH
`define FSS_OFF_CMD      8'h00
`define FSS_OFF_TRACK    8'h04
`define FSS_OFF_SECTOR   8'h08
`define FSS_OFF_DATA     8'h0c
`define FSS_OFF_SPT      8'h10
`define FSS_ST_BUSY      0
`define FSS_ST_CRC       3
`define FSS_ST_SEEK      4
`define FSS_ST_NRDY      7
`define FSS_CMD_H        3
`define FSS_CMD_V        2
`define FSS_CMD_U        4
`define FSS_CMD_M        4
`define FSS_CMD_S        3
`define FSS_CMD_E        2
`define FSS_CMD_C        1
`define FSS_TY_RS        3'h0
`define FSS_TY_STEP      3'h1
`define FSS_TY_IN        3'h2
`define FSS_TY_OUT       3'h3
`define FSS_OP_FORCE     4'hd
`define FSS_AUTO_CMD     8'h03
`define FSS_SPT_RESET    8'h1a
`define FSS_RESTORE_MAX  8'hff
`define FSS_IDLE_REVS    4'hf
`define FSS_VERIFY_REVS  3'h4
`define FSS_SIDE_REVS    3'h5
`define FSS_REV_MAX      3'h7
`define FSS_SEC_BASE     11'h080
`define FSS_CLK_MHZ      100
`define FSS_SETTLE_MS    15
`define FSS_STEP_NS      2000
`define FSS_RATE0_MS     3
`define FSS_RATE1_MS     6
`define FSS_RATE2_MS     10
`define FSS_RATE3_MS     15
`define FSS_SY_RST       4
`define FSS_SY_TZ        3
`define FSS_SY_SETTLED   2
`define FSS_SY_RDY       1
`define FSS_SY_IDX       0
`endif

// [rtl/fss_pkg.sv]
package fss_pkg;
	typedef struct packed {
		logic       valid;
		logic [7:0] track;
		logic       side;
		logic [7:0] sector;
		logic [1:0] len;
		logic       crc_ok;
	} fss_id_type;

	typedef enum logic [10:0] {
		st_idle   = 11'h001,
		st_decide = 11'h002,
		st_pulse  = 11'h004,
		st_rate   = 11'h008,
		st_vchk   = 11'h010,
		st_settle = 11'h020,
		st_engage = 11'h040,
		st_verify = 11'h080,
		st_search = 11'h100,
		st_access = 11'h200,
		st_done   = 11'h400
	} fss_state_type;
endpackage

// [rtl/fss_sequencer.sv]
`timescale 1ns/1ps
`include "fss_regs.svh"
// How it works
// - positioning start loads or unloads head per flag
// - idle fifteen revolutions drops head load
// - verify flag selects destination track verify
// - verify waits settle time then head settled
// - matching good id ends verify cleanly
// - good id wrong track sets seek error
// - bad crc matching id flags crc, retries
// - four revolutions without good id ends
// - update flag moves track per step
// - restore steps out until track zero
// - restore gives up after 255 steps
// - master reset release starts restore
// - seek steps track register toward data
// - step repeats last direction, waits, verifies
// - step in increments, step out decrements
// - sector command loads head, optional settle
// - search matches track, sector, crc
// - four revolutions unmatched sets crc error bit
// - length code gives 128 to 1024 bytes
// - multiple mode advances sector until exceeded
// - side compare within five index pulses
// - busy bit one while command runs
// - sector command refused when drive not ready
module fss_sequencer
	import fss_pkg::*;
#(
	parameter int SETTLE_CYC = `FSS_SETTLE_MS * `FSS_CLK_MHZ * 1000,
	parameter int RATE0_CYC  = `FSS_RATE0_MS * `FSS_CLK_MHZ * 1000,
	parameter int RATE1_CYC  = `FSS_RATE1_MS * `FSS_CLK_MHZ * 1000,
	parameter int RATE2_CYC  = `FSS_RATE2_MS * `FSS_CLK_MHZ * 1000,
	parameter int RATE3_CYC  = `FSS_RATE3_MS * `FSS_CLK_MHZ * 1000
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        master_reset_in_n,
	input  wire logic        track_zero_in_n,
	input  wire logic        head_settled_in,
	input  wire logic        ready_in,
	input  wire logic        index_in,
	input  wire fss_id_type  id_in,
	input  wire logic        data_done_in,
	output logic             head_load_out,
	output logic             step_pulse_out,
	output logic             step_dir_out,
	output logic             side_select_out,
	output logic             interrupt_request_out,
	output logic             sector_access_out,
	output logic      [10:0] sector_bytes_out
);
	localparam int STEP_CYC = `FSS_STEP_NS * `FSS_CLK_MHZ / 1000;

	fss_state_type state_reg;
	logic [4:0]    sync1_reg, sync2_reg;
	logic          idx_d_reg, rst_d_reg, stepped_reg, done_reg, irq_reg;
	logic [7:0]    cmd_reg, track_reg, sector_reg, data_reg, spt_reg;
	logic [7:0]    err_reg, steps_reg, start_cmd;
	logic [23:0]   timer_reg, rate_cyc;
	logic [2:0]    rev_reg, ctype, rev_limit;
	logic [3:0]    idle_reg;
	logic [31:0]   rdata_reg;
	logic          wr_acc, rd_acc, hit, cmd_wr, force_hit, busy;
	logic          start_go, idx_edge, rst_rise, tz, next_dir, upd;
	logic          id_match, side_ok;

	// pins are asynchronous to pclk; stage one is read by stage two only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			idx_d_reg <= 1'b0;
			rst_d_reg <= 1'b0;
		end else begin
			sync1_reg <= {master_reset_in_n, track_zero_in_n,
				head_settled_in, ready_in, index_in};
			sync2_reg <= sync1_reg;
			idx_d_reg <= sync2_reg[`FSS_SY_IDX];
			rst_d_reg <= sync2_reg[`FSS_SY_RST];
		end
	end

	assign idx_edge = sync2_reg[`FSS_SY_IDX] & ~idx_d_reg;
	assign rst_rise = sync2_reg[`FSS_SY_RST] & ~rst_d_reg;
	assign tz       = ~sync2_reg[`FSS_SY_TZ];

	assign wr_acc    = psel & penable & pwrite;
	assign rd_acc    = psel & penable & ~pwrite;
	assign hit       = (paddr == `FSS_OFF_CMD) || (paddr == `FSS_OFF_TRACK) ||
		(paddr == `FSS_OFF_SECTOR) || (paddr == `FSS_OFF_DATA) ||
		(paddr == `FSS_OFF_SPT);
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~hit;
	assign prdata    = rdata_reg;
	assign cmd_wr    = wr_acc && (paddr == `FSS_OFF_CMD);
	assign force_hit = cmd_wr && (pwdata[7:4] == `FSS_OP_FORCE);
	assign busy      = (state_reg != st_idle);
	// a command write while busy is dropped unless it is force interrupt; auto restore beats a host write
	assign start_go  = ~busy & (rst_rise | (cmd_wr & ~force_hit));
	assign start_cmd = rst_rise ? `FSS_AUTO_CMD : pwdata[7:0];
	assign ctype     = cmd_reg[7:5];
	assign upd       = (ctype == `FSS_TY_RS) | cmd_reg[`FSS_CMD_U];

	always_comb begin
		case (ctype)
		`FSS_TY_RS:   next_dir = cmd_reg[4] & (data_reg > track_reg);
		`FSS_TY_IN:   next_dir = 1'b1;
		`FSS_TY_OUT:  next_dir = 1'b0;
		default:      next_dir = step_dir_out;
		endcase
	end

	always_comb begin
		case (cmd_reg[1:0])
		2'h0:    rate_cyc = 24'(RATE0_CYC);
		2'h1:    rate_cyc = 24'(RATE1_CYC);
		2'h2:    rate_cyc = 24'(RATE2_CYC);
		default: rate_cyc = 24'(RATE3_CYC);
		endcase
	end

	assign id_match  = (id_in.track == track_reg);
	assign side_ok   = ~cmd_reg[`FSS_CMD_C] |
		(id_in.side == cmd_reg[`FSS_CMD_S]);
	assign rev_limit = cmd_reg[`FSS_CMD_C] ? `FSS_SIDE_REVS
		: `FSS_VERIFY_REVS;

	// apb side registers; read data is captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg   <= 8'h00;
			data_reg  <= 8'h00;
			spt_reg   <= `FSS_SPT_RESET;
			rdata_reg <= 32'h0000_0000;
		end else begin
			if (start_go)
				cmd_reg <= start_cmd;
			if (wr_acc && paddr == `FSS_OFF_DATA)
				data_reg <= pwdata[7:0];
			if (wr_acc && paddr == `FSS_OFF_SPT)
				spt_reg <= pwdata[7:0];
			if (psel && !penable && !pwrite) begin
				case (paddr)
				`FSS_OFF_CMD:    rdata_reg <= {24'h0, err_reg | 8'(busy)};
				`FSS_OFF_TRACK:  rdata_reg <= {24'h0, track_reg};
				`FSS_OFF_SECTOR: rdata_reg <= {24'h0, sector_reg};
				`FSS_OFF_DATA:   rdata_reg <= {24'h0, data_reg};
				`FSS_OFF_SPT:    rdata_reg <= {24'h0, spt_reg};
				default:         rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	// completion outranks a status read or command write landing with it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_reg <= 1'b0;
		else if (done_reg)
			irq_reg <= 1'b1;
		else if (cmd_wr || (rd_acc && paddr == `FSS_OFF_CMD))
			irq_reg <= 1'b0;
	end
	assign interrupt_request_out = irq_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idle_reg <= 4'h0;
		else if (busy)
			idle_reg <= 4'h0;
		else if (idx_edge && idle_reg != `FSS_IDLE_REVS)
			idle_reg <= idle_reg + 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg         <= st_idle;
			track_reg         <= 8'h00;
			sector_reg        <= 8'h00;
			err_reg           <= 8'h00;
			steps_reg         <= 8'h00;
			timer_reg         <= 24'h00_0000;
			rev_reg           <= 3'h0;
			stepped_reg       <= 1'b0;
			done_reg          <= 1'b0;
			head_load_out     <= 1'b0;
			step_pulse_out    <= 1'b0;
			step_dir_out      <= 1'b0;
			side_select_out   <= 1'b0;
			sector_access_out <= 1'b0;
			sector_bytes_out  <= 11'h000;
		end else begin
			done_reg          <= 1'b0;
			sector_access_out <= 1'b0;
			if (wr_acc && paddr == `FSS_OFF_TRACK)
				track_reg <= pwdata[7:0];
			if (wr_acc && paddr == `FSS_OFF_SECTOR)
				sector_reg <= pwdata[7:0];
			if (timer_reg != 24'h00_0000)
				timer_reg <= timer_reg - 24'h00_0001;
			if (idx_edge && rev_reg != `FSS_REV_MAX)
				rev_reg <= rev_reg + 3'h1;
			if (!busy && idle_reg == `FSS_IDLE_REVS)
				head_load_out <= 1'b0;
			if (force_hit && busy) begin
				step_pulse_out <= 1'b0;
				state_reg      <= st_done;
			end else begin
				case (state_reg)
				st_idle: if (start_go) begin
					err_reg     <= 8'h00;
					steps_reg   <= 8'h00;
					stepped_reg <= 1'b0;
					if (start_cmd[7]) begin
						if (!sync2_reg[`FSS_SY_RDY]) begin
							err_reg[`FSS_ST_NRDY] <= 1'b1;
							state_reg <= st_done;
						end else begin
							head_load_out   <= 1'b1;
							side_select_out <= start_cmd[`FSS_CMD_S];
							timer_reg <= start_cmd[`FSS_CMD_E] ?
								24'(SETTLE_CYC) : 24'h00_0000;
							state_reg <= st_settle;
						end
					end else begin
						head_load_out <= start_cmd[`FSS_CMD_H];
						state_reg     <= st_decide;
					end
				end
				st_decide: begin
					if (ctype == `FSS_TY_RS && !cmd_reg[4]) begin
						if (tz) begin
							track_reg <= 8'h00;
							state_reg <= st_vchk;
						end else if (steps_reg == `FSS_RESTORE_MAX) begin
							err_reg[`FSS_ST_SEEK] <= 1'b1;
							state_reg <= st_done;
						end else begin
							step_dir_out   <= 1'b0;
							step_pulse_out <= 1'b1;
							steps_reg      <= steps_reg + 8'h01;
							timer_reg      <= 24'(STEP_CYC);
							state_reg      <= st_pulse;
						end
					end else if (ctype == `FSS_TY_RS ?
						(track_reg == data_reg) : stepped_reg) begin
						state_reg <= st_vchk;
					end else begin
						step_dir_out   <= next_dir;
						step_pulse_out <= 1'b1;
						stepped_reg    <= 1'b1;
						timer_reg      <= 24'(STEP_CYC);
						state_reg      <= st_pulse;
						if (upd)
							track_reg <= next_dir ? track_reg + 8'h01
								: track_reg - 8'h01;
					end
				end
				st_pulse: if (timer_reg == 24'h00_0000) begin
					step_pulse_out <= 1'b0;
					timer_reg      <= rate_cyc;
					state_reg      <= st_rate;
				end
				st_rate: if (timer_reg == 24'h00_0000)
					state_reg <= st_decide;
				st_vchk: begin
					if (cmd_reg[`FSS_CMD_V]) begin
						head_load_out <= 1'b1;
						timer_reg     <= 24'(SETTLE_CYC);
						state_reg     <= st_settle;
					end else
						state_reg <= st_done;
				end
				st_settle: if (timer_reg == 24'h00_0000)
					state_reg <= st_engage;
				st_engage: if (sync2_reg[`FSS_SY_SETTLED]) begin
					rev_reg   <= 3'h0;
					state_reg <= cmd_reg[7] ? st_search : st_verify;
				end
				st_verify: begin
					if (id_in.valid && id_in.crc_ok) begin
						if (!id_match)
							err_reg[`FSS_ST_SEEK] <= 1'b1;
						state_reg <= st_done;
					end else if (id_in.valid && id_match) begin
						err_reg[`FSS_ST_CRC] <= 1'b1;
					end else if (rev_reg >= `FSS_VERIFY_REVS) begin
						state_reg <= st_done;
					end
				end
				st_search: begin
					if (id_in.valid && id_match && id_in.crc_ok &&
						id_in.sector == sector_reg && side_ok) begin
						sector_bytes_out  <= `FSS_SEC_BASE << id_in.len;
						sector_access_out <= 1'b1;
						state_reg         <= st_access;
					end else if (rev_reg >= rev_limit) begin
						err_reg[`FSS_ST_CRC] <= 1'b1;
						state_reg <= st_done;
					end
				end
				st_access: if (data_done_in) begin
					if (!cmd_reg[`FSS_CMD_M])
						state_reg <= st_done;
					else if (sector_reg >= spt_reg) begin
						sector_reg <= sector_reg + 8'h01;
						err_reg[`FSS_ST_CRC] <= 1'b1;
						state_reg <= st_done;
					end else begin
						sector_reg <= sector_reg + 8'h01;
						rev_reg    <= 3'h0;
						state_reg  <= st_search;
					end
				end
				st_done: begin
					done_reg  <= 1'b1;
					state_reg <= st_idle;
				end
				default: state_reg <= st_idle;
				endcase
			end
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	head_flag_a: assert property (
		state_reg == st_idle && start_go && !start_cmd[7]
		|=> head_load_out == $past(start_cmd[`FSS_CMD_H]))
		else $error("head load does not follow flag");
	idle_drop_a: assert property (
		!busy && idle_reg == `FSS_IDLE_REVS && !start_go |=> !head_load_out)
		else $error("head not dropped after idle revolutions");
	no_verify_a: assert property (
		state_reg == st_vchk && !cmd_reg[`FSS_CMD_V] && !force_hit
		|=> state_reg == st_done ##2 interrupt_request_out)
		else $error("skipped verify did not finish");
	settle_hold_a: assert property (
		state_reg == st_engage && !sync2_reg[`FSS_SY_SETTLED] && !force_hit
		|=> state_reg == st_engage)
		else $error("left settle wait without head settled");
	verify_ok_a: assert property (
		state_reg == st_verify && id_in.valid && id_in.crc_ok && id_match
		&& !force_hit |=> state_reg == st_done ##1 !busy ##1 irq_reg)
		else $error("good id did not complete verify");
	seek_err_a: assert property (
		state_reg == st_verify && id_in.valid && id_in.crc_ok && !id_match
		&& !force_hit |=> err_reg[`FSS_ST_SEEK] && state_reg == st_done)
		else $error("wrong track did not flag seek error");
	crc_retry_a: assert property (
		state_reg == st_verify && id_in.valid && !id_in.crc_ok && id_match
		&& !force_hit |=> err_reg[`FSS_ST_CRC] && state_reg == st_verify)
		else $error("bad crc id not retried");
	verify_tmo_a: assert property (
		state_reg == st_verify && !id_in.valid
		&& rev_reg >= `FSS_VERIFY_REVS
		&& !force_hit |=> state_reg == st_done)
		else $error("verify did not time out");
	restore_max_a: assert property (
		state_reg == st_decide && ctype == `FSS_TY_RS && !cmd_reg[4] && !tz
		&& steps_reg == `FSS_RESTORE_MAX && !force_hit
		|=> err_reg[`FSS_ST_SEEK] ##1 !busy)
		else $error("restore did not stop at 255 steps");
	trk_zero_a: assert property (
		state_reg == st_decide && ctype == `FSS_TY_RS && !cmd_reg[4] && tz
		&& !$past(wr_acc) |=> track_reg == 8'h00 && !step_pulse_out)
		else $error("restore at track zero mismatched");
	not_ready_a: assert property (
		start_go && start_cmd[7] && !sync2_reg[`FSS_SY_RDY]
		|=> err_reg[`FSS_ST_NRDY] ##1 done_reg && !sector_access_out)
		else $error("not ready sector command executed");
	rnf_a: assert property (
		state_reg == st_search && rev_reg >= rev_limit && !id_in.valid
		&& !force_hit |=> err_reg[`FSS_ST_CRC] ##2 irq_reg)
		else $error("record not found missing");

	restore_c: cover property (
		state_reg == st_decide && ctype == `FSS_TY_RS && tz ##[1:20] done_reg);
	access_c: cover property (sector_access_out ##[1:100] data_done_in);
	verify_c: cover property (
		state_reg == st_verify && id_in.valid && id_in.crc_ok);
endmodule // fss_sequencer

// [sim/fss_drive_model.sv]
`timescale 1ns/1ps
module fss_drive_model
	import fss_pkg::*;
#(
	parameter int REV = 600
)(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       head_load_out,
	input  wire logic       step_pulse_out,
	input  wire logic       step_dir_out,
	input  wire logic       sector_access_out,
	input  wire logic       stuck,
	input  wire logic       crc_bad,
	output logic            track_zero_in_n,
	output logic            head_settled_in,
	output logic            index_in,
	output fss_id_type      id_in,
	output logic            data_done_in,
	output logic      [7:0] pos
);
	logic [15:0] cyc_reg;
	logic [15:0] sec;
	logic        step_d_reg;
	logic [3:0]  done_reg;

	// stuck models a broken track-zero sensor
	assign track_zero_in_n = stuck | (pos != 8'h00);
	assign index_in        = cyc_reg < 16'h0010;
	assign sec             = cyc_reg / 16'h003c + 16'h0001;
	assign data_done_in    = done_reg == 4'h1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos        <= 8'h03;
			step_d_reg <= 1'b0;
			cyc_reg    <= 16'h0000;
			head_settled_in <= 1'b0;
		end else begin
			step_d_reg      <= step_pulse_out;
			head_settled_in <= head_load_out;
			cyc_reg <= (cyc_reg == 16'(REV - 1)) ? 16'h0000
				: cyc_reg + 16'h0001;
			if (step_pulse_out && !step_d_reg) begin
				if (step_dir_out && pos < 8'h4c)
					pos <= pos + 8'h01;
				else if (!step_dir_out && pos != 8'h00)
					pos <= pos - 8'h01;
			end
		end
	end

	// ten sectors a turn; between fields the bus keeps toggling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_in <= '0;
		end else if (head_load_out && cyc_reg % 16'h003c == 16'h001e) begin
			id_in <= '{valid: 1'b1, track: pos, side: 1'b0, sector: sec[7:0],
				len: sec[1:0], crc_ok: !crc_bad};
		end else begin
			id_in <= {1'b0, ~id_in[$bits(fss_id_type)-2:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			done_reg <= 4'h0;
		else if (sector_access_out)
			done_reg <= 4'ha;
		else if (done_reg != 4'h0)
			done_reg <= done_reg - 4'h1;
	end
endmodule // fss_drive_model

// [sim/floppy_seek_sector_sequencer_tb.sv]
`timescale 1ns/1ps
`include "fss_regs.svh"
module floppy_seek_sector_sequencer_tb
	import fss_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, err_seen;
	logic [7:0]  paddr, pos;
	logic [31:0] pwdata, prdata, rd_data;
	logic        pready, pslverr, master_reset_in_n, track_zero_in_n;
	logic        head_settled_in, ready_in, index_in, data_done_in;
	logic        head_load_out, step_pulse_out, step_dir_out, step_d;
	logic        side_select_out, interrupt_request_out, sector_access_out;
	logic        stuck, crc_bad;
	logic [10:0] sector_bytes_out, last_bytes;
	fss_id_type  id_in;
	int          num_errors, checks_done, steps, accs, a;
	logic [7:0]  s_cmd [4] = '{8'h58, 8'h60, 8'h30, 8'h24};
	logic [7:0]  s_trk [4] = '{8'h06, 8'h06, 8'h05, 8'h05};
	logic [7:0]  s_pos [4] = '{8'h06, 8'h05, 8'h04, 8'h03};
	logic [7:0]  s_st  [4] = '{8'h00, 8'h00, 8'h00, 8'h10};
	logic        s_hd  [4] = '{1'b1, 1'b0, 1'b0, 1'b0};

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	fss_sequencer #(.SETTLE_CYC(20), .RATE0_CYC(10), .RATE1_CYC(12),
		.RATE2_CYC(14), .RATE3_CYC(16)) i_fss_sequencer (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.master_reset_in_n, .track_zero_in_n, .head_settled_in, .ready_in,
		.index_in, .id_in, .data_done_in, .head_load_out, .step_pulse_out,
		.step_dir_out, .side_select_out, .interrupt_request_out,
		.sector_access_out, .sector_bytes_out);

	fss_drive_model i_fss_drive_model (.pclk, .presetn, .head_load_out,
		.step_pulse_out, .step_dir_out, .sector_access_out, .stuck, .crc_bad,
		.track_zero_in_n, .head_settled_in, .index_in, .id_in, .data_done_in,
		.pos);

	always @(posedge pclk) begin
		step_d <= step_pulse_out;
		if (step_pulse_out === 1'b1 && step_d !== 1'b1)
			steps++;
		if (sector_access_out === 1'b1) begin
			accs++;
			last_bytes = sector_bytes_out;
		end
	end

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	// entered just after an edge; leaves one idle cycle after the access
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_data = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		apb(1'b1, ad, {24'h0, d});
	endtask

	task automatic rd(input string nm, input logic [7:0] ad, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, ad, 32'h0);
		chk(nm, e, rd_data & m);
	endtask

	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (interrupt_request_out !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
		chk("irq", 32'h1, interrupt_request_out);
	endtask

	task automatic cmd(input logic [7:0] c, input int lim);
		wr(`FSS_OFF_CMD, c);
		wait_irq(lim);
	endtask

	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; master_reset_in_n = 1'b1;
		ready_in = 1'b1; stuck = 1'b0; crc_bad = 1'b0; step_d = 1'b0;
		num_errors = 0; checks_done = 0; steps = 0; accs = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		wait_irq(5000);
		rd("status", `FSS_OFF_CMD, 32'h19, 32'h0);
		rd("track", `FSS_OFF_TRACK, 32'hff, 32'h0);
		chk("pos", 32'h0, pos);
		rd("spt", `FSS_OFF_SPT, 32'hff, 32'h1a);
		apb(1'b0, 8'h20, 32'h0);
		chk("pslverr", 32'h1, err_seen);
		$display("reset test done");
		steps = 0;
		wr(`FSS_OFF_DATA, 8'h05);
		wr(`FSS_OFF_CMD, 8'h1c);
		rd("busy", `FSS_OFF_CMD, 32'h1, 32'h1);
		wait_irq(20000);
		rd("status", `FSS_OFF_CMD, 32'h19, 32'h0);
		rd("track", `FSS_OFF_TRACK, 32'hff, 32'h5);
		chk("steps", 32'h5, steps);
		chk("head", 32'h1, head_load_out);
		$display("seek test done");
		foreach (s_cmd[i]) begin
			cmd(s_cmd[i], 3000);
			rd("status", `FSS_OFF_CMD, 32'h19, s_st[i]);
			rd("track", `FSS_OFF_TRACK, 32'hff, s_trk[i]);
			chk("pos", s_pos[i], pos);
			if (i < 3)
				chk("head", s_hd[i], head_load_out);
		end
		$display("step test done");
		cmd(8'h08, 3000);
		rd("track", `FSS_OFF_TRACK, 32'hff, 32'h0);
		chk("pos", 32'h0, pos);
		crc_bad <= 1'b1;
		wr(`FSS_OFF_DATA, 8'h00);
		cmd(8'h14, 5000);
		rd("status", `FSS_OFF_CMD, 32'h19, 32'h08);
		crc_bad <= 1'b0;
		$display("crc test done");
		wr(`FSS_OFF_SPT, 8'h0a);
		for (int s = 1; s <= 4; s++) begin
			wr(`FSS_OFF_SECTOR, 8'(s));
			cmd(s[0] ? 8'h80 : 8'ha0, 3000);
			chk("bytes", 11'h080 << s[1:0], last_bytes);
			rd("status", `FSS_OFF_CMD, 32'h19, 32'h0);
		end
		wr(`FSS_OFF_SECTOR, 8'h09);
		a = accs;
		cmd(8'h90, 5000);
		chk("accesses", 32'h2, accs - a);
		rd("status", `FSS_OFF_CMD, 32'h19, 32'h08);
		rd("sector", `FSS_OFF_SECTOR, 32'hff, 32'h0b);
		wr(`FSS_OFF_SECTOR, 8'h0c);
		cmd(8'h80, 5000);
		rd("status", `FSS_OFF_CMD, 32'h19, 32'h08);
		// missing sector keeps it busy for turns; force must cut it short
		wr(`FSS_OFF_CMD, 8'h80);
		repeat (50) @(posedge pclk);
		cmd(8'hd0, 100);
		rd("status", `FSS_OFF_CMD, 32'h19, 32'h0);
		wr(`FSS_OFF_SECTOR, 8'h02);
		cmd(8'h8a, 6000);
		rd("status", `FSS_OFF_CMD, 32'h19, 32'h08);
		chk("side", 32'h1, side_select_out);
		ready_in <= 1'b0;
		// let the two sync stages see the drop before the command lands
		repeat (3) @(posedge pclk);
		a = accs;
		cmd(8'h80, 3000);
		chk("accesses", a, accs);
		rd("not ready", `FSS_OFF_CMD, 32'h81, 32'h80);
		ready_in <= 1'b1;
		repeat (5) @(posedge pclk);
		cmd(8'h82, 3000);
		rd("status", `FSS_OFF_CMD, 32'h19, 32'h0);
		chk("head", 32'h1, head_load_out);
		$display("sector test done");
		// fifteen turns plus margin, turns are 600 cycles in the model
		repeat (17 * 600) @(posedge pclk);
		chk("head", 32'h0, head_load_out);
		$display("head test done");
		stuck <= 1'b1;
		steps = 0;
		cmd(8'h00, 70000);
		chk("steps", 32'd255, steps);
		rd("status", `FSS_OFF_CMD, 32'h19, 32'h10);
		$display("restore test done");
		wrap_up();
	end

	initial begin
		repeat (100000) @(posedge pclk);
		num_errors++;
		$display("unexpected run length: expected end, seen timeout");
		wrap_up();
	end
endmodule // floppy_seek_sector_sequencer_tb
